// ### bench/bit_timer_mark_space_bench.sv
// Self-checking bench for the bit timer
`timescale 1ns/100ps
module bit_timer_mark_space_bench;
    logic clk, reset, ioWrite, ioRead, edgeReq, stall, rdPrev;
    logic [7:0] ioAddr, ioWrData, ioRdData, irqVector, cnt;
    logic edgePin, txReady, txLevel, txKey, doneIrq, emptyIrq;
    logic [15:0] expQ[$];
    logic [15:0] e;
    int fails, n_compared, seed, cyc, c1, c2, n, t0, swOvf;
    bit_timer_mark_space DUT (.clk(clk), .reset(reset), .ioAddr(ioAddr), .ioWrite(ioWrite),
        .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData), .edge_input_pin(edgePin),
        .txReady(txReady), .txLevel(txLevel), .txKey(txKey), .done_or_edge_irq(doneIrq),
        .buffer_empty_irq(emptyIrq), .irqVector(irqVector));
    link_partner far (.clk(clk), .stall(stall), .pinReq(edgeReq), .txLevel(txLevel),
        .txKey(txKey), .txReady(txReady), .pinOut(edgePin));
    task test_done;
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task check(input logic [7:0] g, input logic [7:0] x);
        n_compared++;
        if (g !== x) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task acc(input logic [7:0] a, input logic [7:0] d, input logic r);
        @(posedge clk);
        #5 ioAddr = a;
        ioWrData = d;
        ioWrite = !r;
        ioRead = r;
        @(posedge clk);
        #5 ioWrite = 0;
        ioRead = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        expQ.push_back({m, x});
        acc(a, 8'h00, 1'b1);
    endtask
    task waitIrq(input bit which, output int c);
        c = 0;
        do begin
            @(negedge clk);
            c++;
        end while (((which ? emptyIrq : doneIrq) !== 1'b1) && c < 3000);
        if (c >= 3000) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, 8'h00, 8'h01);
            test_done();
        end
    endtask
    // Read data is due one cycle after the strobe; the oldest note is taken then
    always @(negedge clk) begin
        cyc++;
        if (rdPrev && expQ.size() > 0) begin
            e = expQ.pop_front();
            check(ioRdData & e[15:8], e[7:0]);
        end
        rdPrev = ioRead;
    end
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    initial begin
        reset = 1; ioWrite = 0; ioRead = 0; ioAddr = 8'h00; ioWrData = 8'h00;
        edgeReq = 0; stall = 0; rdPrev = 0; seed = 71424; cyc = 0; swOvf = 0;
        repeat (6) @(posedge clk);
        #5 reset = 0;
        rd(8'h20, 8'hff, bit_timer_pkg::PERIOD_COUNT_LOW_RESET);
        rd(8'h21, 8'hff, bit_timer_pkg::CONTROL_STATUS_RESET);
        rd(8'h22, 8'hff, 8'h00);
        wr_rd: begin
            acc(8'h20, 8'h5a, 1'b0);
            rd(8'h20, 8'hff, 8'h5a);
            acc(8'h21, 8'hc5, 1'b0);
            rd(8'h21, 8'hff, 8'hc0);
        end
        $display("registers done");
        for (int m = 0; m < 4; m++) begin
            acc(8'h21, 8'(m << 4), 1'b0);
            repeat (2) @(posedge clk);
            check({7'h00, txKey}, {7'h00, m == 3});
        end
        acc(8'h21, 8'h00, 1'b0);
        rd(8'h21, 8'hfa, 8'h00);
        cnt = 8'h10 + 8'($random(seed) & 8'h0f);
        acc(8'h20, cnt, 1'b0);
        acc(8'h21, 8'h3a, 1'b0);
        waitIrq(1, c1);
        check(irqVector, bit_timer_pkg::VECTOR_EMPTY_OVF);
        waitIrq(0, c2);
        check(irqVector, bit_timer_pkg::VECTOR_DONE_EDGE);
        check(8'(c2), cnt + 8'h01);
        rd(8'h21, 8'h05, 8'h05);
        rd(8'h21, 8'h05, 8'h00);
        check({7'h00, txLevel}, 8'h01);
        // Next bit goes in only once the buffer is known to be empty
        acc(8'h21, 8'h38, 1'b0);
        waitIrq(1, c1);
        @(posedge clk);
        #5 check({7'h00, txLevel}, 8'h00);
        rd(8'h21, 8'h05, 8'h01);
        acc(8'h21, 8'h00, 1'b0);
        $display("transmit done");
        stall = 1;
        acc(8'h20, 8'h00, 1'b0);
        acc(8'h21, 8'h28, 1'b0);
        n = 30 + ($random(seed) & 15);
        t0 = cyc;
        edgeReq = 1;
        waitIrq(0, c1);
        check(irqVector, bit_timer_pkg::VECTOR_DONE_EDGE);
        rd(8'h21, 8'h06, 8'h06);
        while (cyc < t0 + n) @(posedge clk);
        #5 edgeReq = 0;
        waitIrq(0, c1);
        rd(8'h20, 8'hff, 8'(n));
        rd(8'h21, 8'hc6, 8'h04);
        waitIrq(1, c1);
        check(irqVector, bit_timer_pkg::VECTOR_EMPTY_OVF);
        swOvf++;
        $display("receive done");
        test_done();
    end
endmodule // bit_timer_mark_space_bench

// ### bench/link_partner.sv
// Model of the transmitter keying path and the edge input pin
`timescale 1ns/100ps
module link_partner (
    input wire logic clk,
    input wire logic stall,
    input wire logic pinReq,
    input wire logic txLevel,
    input wire logic txKey,
    output logic txReady,
    output logic pinOut
);
    int s = 71424;
    initial begin
        txReady = 1'b1;
        pinOut = 1'b0;
    end
    // Transmitter stalls at random while asked to
    always @(posedge clk) begin
        txReady <= !stall || ($random(s) & 1);
        pinOut <= pinReq;
    end
endmodule // link_partner

// ### hw/bit_timer_mark_space.sv
// Bit timer: timed marks/spaces for the transmitter, edge timestamps on receive
// Contract
// - The period count is ten bits, low eight from the count register, top two from control bits 7:6.
// - Each mark or space lasts period count plus one clock cycles.
// - Control bits 5:4 pick disabled, transmit unkeyed, receive, or transmit keyed.
// - With control bit 3 set, each flag raises its own interrupt request when it sets.
// - The empty/overflow interrupt vectors to 0x04 and the done/edge interrupt to 0x02.
// - In transmit, the done flag sets when the buffer is empty and the counter reaches zero.
// - In receive, the done/edge flag sets on each edge of the edge input pin.
// - Reading the control register clears bits 2 and 0, which software cannot write.
// - In transmit, control bit 1 is a one-bit buffer; taking it sets the empty flag.
// - In receive, control bit 1 reads 1 after a rising edge and 0 after a falling edge.
// - In receive, the period count holds cycles since the previous edge unless overflowed.
// - In receive, the empty/overflow flag sets when the edge counter overflows.
// - The clock is the crystal divided by 16, 32, 64 or 128, chosen outside this block.
`timescale 1ns/100ps
module bit_timer_mark_space (
    input wire logic clk, // divided system clock supplied from outside
    input wire logic reset,
    input wire logic [7:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    input wire logic edge_input_pin,
    input wire logic txReady,
    output logic txLevel,
    output logic txKey,
    output logic done_or_edge_irq,
    output logic buffer_empty_irq,
    output logic [7:0] irqVector
);
    typedef struct packed {
        logic [7:0] periodLow;
        logic [1:0] periodHi;
        logic [1:0] mode;
        logic irqEn;
        logic doneFlag;
        logic dataBit;
        logic bufFull;
        logic emptyFlag;
        logic [9:0] counter;
        logic level;
        logic pinPrev;
        logic ovfSeen;
        logic [7:0] rdData;
        logic irqDone;
        logic irqEmpty;
        logic [7:0] vector;
        logic txLevel;
        logic txKey;
    } timer_state_t;
    timer_state_t st_q, st_d;

    logic [9:0] periodCount;
    logic isTx, isRx, expire, rdCtl, bufInReady, bufOutValid, bufOutData;
    logic pushLevel;

    assign periodCount = {st_q.periodHi, st_q.periodLow};
    assign isTx = (st_q.mode == bit_timer_pkg::MODE_TX_UNKEYED) ||
        (st_q.mode == bit_timer_pkg::MODE_TX_KEYED);
    assign isRx = (st_q.mode == bit_timer_pkg::MODE_RX);
    assign expire = isTx && (st_q.counter == bit_timer_pkg::CNT_ZERO) && bufInReady;
    assign rdCtl = ioRead && (ioAddr == bit_timer_pkg::ADDR_CONTROL_STATUS);
    assign pushLevel = expire;

    mark_buffer u_buf (
        .clk(clk),
        .reset(reset),
        .inValid(pushLevel),
        .inData(st_q.bufFull ? st_q.dataBit : st_q.level),
        .inReady(bufInReady),
        .outValid(bufOutValid),
        .outData(bufOutData),
        .outReady(txReady)
    );

    always_comb begin
        st_d = st_q;
        st_d.irqDone = 1'b0;
        st_d.irqEmpty = 1'b0;
        st_d.pinPrev = edge_input_pin;
        // Reads clear flags first so a same-cycle event still sets them
        if (rdCtl) begin
            st_d.doneFlag = 1'b0;
            st_d.emptyFlag = 1'b0;
        end
        if (ioWrite) begin
            if (ioAddr == bit_timer_pkg::ADDR_PERIOD_COUNT_LOW) begin
                st_d.periodLow = ioWrData;
            end else if (ioAddr == bit_timer_pkg::ADDR_CONTROL_STATUS) begin
                st_d.periodHi = ioWrData[bit_timer_pkg::BIT_PERIOD_HI_MSB:
                    bit_timer_pkg::BIT_PERIOD_HI_LSB];
                st_d.mode = ioWrData[bit_timer_pkg::BIT_MODE_MSB:bit_timer_pkg::BIT_MODE_LSB];
                st_d.irqEn = ioWrData[bit_timer_pkg::BIT_IRQ_EN];
                st_d.dataBit = ioWrData[bit_timer_pkg::BIT_DATA];
                st_d.bufFull = 1'b1;
                st_d.counter = bit_timer_pkg::CNT_ZERO;
            end
        end
        if (isTx) begin
            if (st_q.counter != bit_timer_pkg::CNT_ZERO) begin
                st_d.counter = st_q.counter - bit_timer_pkg::CNT_ONE;
            end else if (expire) begin
                st_d.counter = periodCount;
                if (st_q.bufFull) begin
                    st_d.level = st_q.dataBit;
                    st_d.bufFull = 1'b0;
                    st_d.emptyFlag = 1'b1;
                    st_d.irqEmpty = st_q.irqEn;
                end else begin
                    st_d.doneFlag = 1'b1;
                    st_d.irqDone = st_q.irqEn;
                end
            end
        end else if (isRx) begin
            if (edge_input_pin != st_q.pinPrev) begin
                st_d.periodHi = st_q.counter[9:8];
                st_d.periodLow = st_q.counter[7:0];
                st_d.dataBit = edge_input_pin;
                st_d.counter = bit_timer_pkg::CNT_ONE;
                st_d.doneFlag = 1'b1;
                st_d.irqDone = st_q.irqEn;
            end else if (st_q.counter == bit_timer_pkg::CNT_MAX) begin
                st_d.counter = bit_timer_pkg::CNT_ZERO;
                st_d.emptyFlag = 1'b1;
                st_d.irqEmpty = st_q.irqEn;
            end else begin
                st_d.counter = st_q.counter + bit_timer_pkg::CNT_ONE;
            end
        end else begin
            st_d.counter = bit_timer_pkg::CNT_ZERO;
        end
        if (rdCtl) begin
            st_d.rdData = {st_q.periodHi, st_q.mode, st_q.irqEn, st_q.doneFlag,
                st_q.dataBit, st_q.emptyFlag};
        end else if (ioRead && ioAddr == bit_timer_pkg::ADDR_PERIOD_COUNT_LOW) begin
            st_d.rdData = st_q.periodLow;
        end else begin
            st_d.rdData = 8'h00;
        end
        if (st_d.irqEmpty) begin
            st_d.vector = bit_timer_pkg::VECTOR_EMPTY_OVF;
        end else if (st_d.irqDone) begin
            st_d.vector = bit_timer_pkg::VECTOR_DONE_EDGE;
        end
        st_d.txLevel = bufOutValid ? bufOutData : st_q.txLevel;
        st_d.txKey = (st_q.mode == bit_timer_pkg::MODE_TX_KEYED);
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ioRdData = st_q.rdData;
    assign txLevel = st_q.txLevel;
    assign txKey = st_q.txKey;
    assign done_or_edge_irq = st_q.irqDone;
    assign buffer_empty_irq = st_q.irqEmpty;
    assign irqVector = st_q.vector;

    chk_done_irq_gate: assert property (@(posedge clk) disable iff (reset)
        done_or_edge_irq |-> $past(st_q.irqEn)) else $error("done irq without enable");
    chk_vector_empty: assert property (@(posedge clk) disable iff (reset)
        buffer_empty_irq |-> irqVector == bit_timer_pkg::VECTOR_EMPTY_OVF)
        else $error("wrong empty vector");
    chk_read_clears: assert property (@(posedge clk) disable iff (reset)
        rdCtl && !isRx && !isTx |=> !st_q.doneFlag && !st_q.emptyFlag)
        else $error("flags not cleared by read");
    chk_rx_edge_flag: assert property (@(posedge clk) disable iff (reset)
        isRx && !ioWrite && edge_input_pin != st_q.pinPrev |=> st_q.doneFlag)
        else $error("edge missed");
    chk_rx_polarity: assert property (@(posedge clk) disable iff (reset)
        isRx && !ioWrite && $rose(edge_input_pin) |=> st_q.dataBit)
        else $error("edge polarity wrong");
    chk_tx_reload: assert property (@(posedge clk) disable iff (reset)
        expire && !ioWrite |=> st_q.counter == $past(periodCount))
        else $error("counter not reloaded");
    chk_tx_key: assert property (@(posedge clk) disable iff (reset)
        st_q.mode == bit_timer_pkg::MODE_TX_KEYED && !ioWrite |=> txKey)
        else $error("key not asserted");
    chk_rx_overflow: assert property (@(posedge clk) disable iff (reset)
        isRx && !ioWrite && st_q.counter == bit_timer_pkg::CNT_MAX &&
        edge_input_pin == st_q.pinPrev
        |=> st_q.emptyFlag) else $error("overflow flag missed");
endmodule // bit_timer_mark_space

// ### hw/bit_timer_pkg.sv
// Constants shared by the bit timer design
package bit_timer_pkg;
    localparam logic [7:0] ADDR_PERIOD_COUNT_LOW = 8'h20;
    localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h21;
    localparam logic [7:0] PERIOD_COUNT_LOW_RESET = 8'h00;
    localparam logic [7:0] CONTROL_STATUS_RESET = 8'h00;
    localparam int CNT_W = 10;
    localparam int BIT_PERIOD_HI_MSB = 7;
    localparam int BIT_PERIOD_HI_LSB = 6;
    localparam int BIT_MODE_MSB = 5;
    localparam int BIT_MODE_LSB = 4;
    localparam int BIT_IRQ_EN = 3;
    localparam int BIT_DONE_FLAG = 2;
    localparam int BIT_DATA = 1;
    localparam int BIT_EMPTY_FLAG = 0;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_TX_UNKEYED = 2'h1;
    localparam logic [1:0] MODE_RX = 2'h2;
    localparam logic [1:0] MODE_TX_KEYED = 2'h3;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;
    localparam logic [7:0] VECTOR_DONE_EDGE = 8'h02;
    localparam logic [7:0] VECTOR_EMPTY_OVF = 8'h04;
    localparam int BUF_DEPTH = 2;
endpackage : bit_timer_pkg

// ### hw/mark_buffer.sv
// Two-entry valid/ready buffer for timed mark/space levels
`timescale 1ns/100ps
module mark_buffer (
    input wire logic clk,
    input wire logic reset,
    input wire logic inValid,
    input wire logic inData,
    output logic inReady,
    output logic outValid,
    output logic outData,
    input wire logic outReady
);
    typedef struct packed {
        logic [1:0] data;
        logic [1:0] count;
    } buf_state_t;
    buf_state_t st_q, st_d;
    logic push, pop;

    assign inReady = (st_q.count != 2'(bit_timer_pkg::BUF_DEPTH));
    assign outValid = (st_q.count != 2'h0);
    assign outData = st_q.data[0];

    always_comb begin
        st_d = st_q;
        push = inValid && inReady;
        pop = outValid && outReady;
        if (pop) begin
            st_d.data = {1'b0, st_q.data[1]};
            st_d.count = st_q.count - 2'h1;
        end
        if (push) begin
            st_d.data[st_d.count[0]] = inData;
            st_d.count = st_d.count + 2'h1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule // mark_buffer
